// ### hw/acf_pkg.sv
// Constants for the auxiliary control register and configuration word block.
// Assumes an AHB-Lite slave with 32-bit data and one aligned word per register.
package acf_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] ACF_AUX_CTRL_IDX = 16'h00F8;
    localparam logic [15:0] ACF_CFG_WORD_IDX = 16'h7FFF;

    // Auxiliary control field positions
    localparam int ACF_WDT_CLR_BIT = 7;
    localparam int ACF_TM3_CLR_BIT = 6;
    localparam int ACF_TOUCH_SOC_BIT = 5;
    localparam int ACF_ADC_SOC_BIT = 4;
    localparam int ACF_LVR_OFF_BIT = 3;
    localparam int ACF_T2_SEL_BIT = 2;
    localparam int ACF_T1_SEL_BIT = 1;
    localparam logic [7:0] ACF_AUX_RESET = 8'h00;

    // Configuration word field positions
    localparam int ACF_PROT_N_BIT = 7;
    localparam int ACF_XRST_N_BIT = 6;
    localparam int ACF_LVR_THR_HI = 5;
    localparam int ACF_LVR_THR_LO = 3;
    localparam int ACF_TBL_LOCK_N_BIT = 1;
    // Safest value until the word is captured: protected, pin reset on, locked
    localparam logic [7:0] ACF_CFG_SAFE = 8'h00;

    // Slow clock divider for the timer count inputs
    localparam int ACF_SLOW_DIV = 16;
    localparam int ACF_DIV_W = $clog2(ACF_SLOW_DIV);

    // AHB-Lite encodings
    localparam logic [2:0] ACF_HSIZE_WORD = 3'h2;
    localparam logic ACF_HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        ACF_SEL_NONE,
        ACF_SEL_AUX,
        ACF_SEL_CFG
    } acf_sel_e;
endpackage

// ### hw/acf_cfg_if.sv
// Carries the captured configuration word from the capture module to the top.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
`default_nettype none
interface acf_cfg_if;
    logic [7:0] cfg_word;
    logic valid;
    modport source (output cfg_word, output valid);
    modport sink (input cfg_word, input valid);
endinterface
`default_nettype wire

// ### hw/acf_cfg_capture.sv
// Captures the non-volatile configuration word once after reset and holds it.
// Assumes the configuration word input is settled when reset is released.
`timescale 1ns/1ps
`default_nettype none
module acf_cfg_capture (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Configuration word from non-volatile storage
    input wire logic [7:0] i_cfg_word,
    // Captured word toward the top
    acf_cfg_if.source cfg
);
    import acf_pkg::*;

    typedef struct packed {
        logic captured;
        logic [7:0] word;
    } acf_cap_s;

    acf_cap_s cap_ff;
    acf_cap_s nxt_cap;

    always_comb begin
        nxt_cap = cap_ff;
        // Taken once, at the first edge after reset, then frozen
        if (!cap_ff.captured) begin
            nxt_cap.word = i_cfg_word;
            nxt_cap.captured = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cap_ff <= '{captured: 1'b0, word: ACF_CFG_SAFE};
        end else begin
            cap_ff <= nxt_cap;
        end
    end

    assign cfg.cfg_word = cap_ff.word;
    assign cfg.valid = cap_ff.captured;
endmodule
`default_nettype wire

// ### hw/acf_aux_ctrl_top.sv
// Auxiliary control register and configuration word, reached over AHB-Lite.
// Assumes a single AHB-Lite master, synchronous inputs and one system clock.
`timescale 1ns/1ps
`default_nettype none
module acf_aux_ctrl_top (
    // Clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RESET,
    // AHB-Lite slave
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    // Configuration word storage
    input wire logic [7:0] I_CFG_WORD,
    output logic O_CFG_VALID,
    // Watchdog and Timer3 clear pulses
    output logic O_WDT_CLEAR,
    output logic O_TIMER3_CLEAR,
    // Touch-key and ADC converters
    input wire logic I_TOUCH_DONE,
    input wire logic I_SYSTEM_CLOCK_FAST,
    input wire logic I_ADC_DONE,
    output logic O_TOUCH_START,
    output logic O_ADC_START,
    output logic O_TOUCH_BUSY,
    output logic O_ADC_BUSY,
    // Timer count sources
    input wire logic I_SLOW_CLOCK,
    input wire logic I_TIMER1_PIN,
    input wire logic I_TIMER2_PIN,
    input wire logic I_TIMER1_COUNTER_MODE,
    input wire logic I_TIMER2_COUNTER_MODE,
    output logic O_TIMER1_COUNT_IN,
    output logic O_TIMER2_COUNT_IN,
    // Reset and protection controls
    output logic O_LOW_VOLT_RESET_EN,
    output logic [2:0] O_LOW_VOLT_THRESHOLD_SEL,
    output logic O_CODE_PROTECT,
    output logic O_EXT_PIN_RESET_EN,
    // Table read access check
    input wire logic I_TBL_ACC_REQ,
    input wire logic I_TBL_ACC_LOCK_AREA,
    output logic O_TBL_ACC_BLOCK
);
    import acf_pkg::*;

    typedef struct packed {
        logic [7:0] aux;
        logic wr_pend;
        acf_sel_e wr_sel;
        logic [31:0] hrdata;
        logic hreadyout;
        logic slow_prev;
        logic [ACF_DIV_W-1:0] div_cnt;
        logic div16;
        logic wdt_clr;
        logic tm3_clr;
        logic tk_start;
        logic adc_start;
        logic t1_in;
        logic t2_in;
        logic lvr_en;
        logic [2:0] lvr_thr;
        logic protect;
        logic xrst_en;
        logic tbl_block;
        logic cfg_valid;
    } acf_state_s;

    localparam acf_state_s ACF_STATE_RESET = '{
        aux: ACF_AUX_RESET,
        wr_pend: 1'b0,
        wr_sel: ACF_SEL_NONE,
        hrdata: 32'h0000_0000,
        hreadyout: 1'b1,
        slow_prev: 1'b0,
        div_cnt: '0,
        div16: 1'b0,
        wdt_clr: 1'b0,
        tm3_clr: 1'b0,
        tk_start: 1'b0,
        adc_start: 1'b0,
        t1_in: 1'b0,
        t2_in: 1'b0,
        lvr_en: 1'b1,
        lvr_thr: 3'h0,
        protect: 1'b1,
        xrst_en: 1'b1,
        tbl_block: 1'b0,
        cfg_valid: 1'b0
    };

    acf_state_s st_ff;
    acf_state_s nxt_st;

    acf_cfg_if cfg_bus ();

    acf_cfg_capture u_cfg_capture (
        .i_clk(I_CLK_SYS),
        .i_reset(I_RESET),
        .i_cfg_word(I_CFG_WORD),
        .cfg(cfg_bus)
    );

    // Word-aligned decode of a register index; anything else is unmapped
    function automatic acf_sel_e decode_addr(input logic [31:0] addr);
        acf_sel_e sel;
        sel = ACF_SEL_NONE;
        if (addr[31:18] == 14'h0000 && addr[1:0] == 2'h0) begin
            if (addr[17:2] == ACF_AUX_CTRL_IDX) begin
                sel = ACF_SEL_AUX;
            end else if (addr[17:2] == ACF_CFG_WORD_IDX) begin
                sel = ACF_SEL_CFG;
            end
        end
        return sel;
    endfunction

    // Counter-mode source select shared by both timers
    function automatic logic count_src(input logic counter_mode, input logic sel_slow,
                                       input logic slow_div, input logic pin);
        logic src;
        src = 1'b0;
        if (counter_mode) begin
            src = sel_slow ? slow_div : pin;
        end
        return src;
    endfunction

    always_comb begin
        logic [7:0] wr;
        logic slow_rise;
        acf_sel_e sel;
        wr = I_HWDATA[7:0];
        slow_rise = 1'b0;
        sel = ACF_SEL_NONE;
        nxt_st = st_ff;

        // Strobes live for one cycle only
        nxt_st.aux[ACF_WDT_CLR_BIT] = 1'b0;
        nxt_st.aux[ACF_TM3_CLR_BIT] = 1'b0;
        nxt_st.aux[0] = 1'b0;
        nxt_st.tk_start = 1'b0;
        nxt_st.adc_start = 1'b0;

        // End-of-conversion clears; touch only when the clock is fast enough
        if (I_TOUCH_DONE && I_SYSTEM_CLOCK_FAST) begin
            nxt_st.aux[ACF_TOUCH_SOC_BIT] = 1'b0;
        end
        if (I_ADC_DONE) begin
            nxt_st.aux[ACF_ADC_SOC_BIT] = 1'b0;
        end

        // Data phase write; a write of one wins over a same-cycle end of conversion
        if (st_ff.wr_pend && st_ff.wr_sel == ACF_SEL_AUX) begin
            nxt_st.aux[ACF_WDT_CLR_BIT] = wr[ACF_WDT_CLR_BIT];
            nxt_st.aux[ACF_TM3_CLR_BIT] = wr[ACF_TM3_CLR_BIT];
            nxt_st.aux[ACF_TOUCH_SOC_BIT] = wr[ACF_TOUCH_SOC_BIT];
            nxt_st.tk_start = wr[ACF_TOUCH_SOC_BIT];
            // Writing zero aborts the flag ahead of the converter
            nxt_st.aux[ACF_ADC_SOC_BIT] = wr[ACF_ADC_SOC_BIT];
            nxt_st.adc_start = wr[ACF_ADC_SOC_BIT];
            nxt_st.aux[ACF_LVR_OFF_BIT] = wr[ACF_LVR_OFF_BIT];
            nxt_st.aux[ACF_T2_SEL_BIT] = wr[ACF_T2_SEL_BIT];
            nxt_st.aux[ACF_T1_SEL_BIT] = wr[ACF_T1_SEL_BIT];
        end

        // Address phase; zero wait states, always OKAY
        nxt_st.wr_pend = 1'b0;
        nxt_st.hreadyout = 1'b1;
        if (I_HSEL && I_HREADY && I_HTRANS[1]) begin
            sel = decode_addr(I_HADDR);
            nxt_st.wr_sel = sel;
            nxt_st.wr_pend = I_HWRITE && (I_HSIZE == ACF_HSIZE_WORD);
            if (!I_HWRITE) begin
                case (sel)
                    ACF_SEL_AUX: begin
                        nxt_st.hrdata = {24'h00_0000, nxt_st.aux};
                    end
                    ACF_SEL_CFG: begin
                        nxt_st.hrdata = {24'h00_0000, cfg_bus.cfg_word};
                    end
                    default: begin
                        nxt_st.hrdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // Slow clock divided by 16 from sampled rising edges
        slow_rise = I_SLOW_CLOCK && !st_ff.slow_prev;
        nxt_st.slow_prev = I_SLOW_CLOCK;
        if (slow_rise) begin
            nxt_st.div_cnt = st_ff.div_cnt + 1'b1;
        end
        nxt_st.div16 = nxt_st.div_cnt[ACF_DIV_W-1];

        nxt_st.t2_in = count_src(I_TIMER2_COUNTER_MODE, st_ff.aux[ACF_T2_SEL_BIT],
                                 st_ff.div16, I_TIMER2_PIN);
        nxt_st.t1_in = count_src(I_TIMER1_COUNTER_MODE, st_ff.aux[ACF_T1_SEL_BIT],
                                 st_ff.div16, I_TIMER1_PIN);

        // Pulses follow the strobe bits
        nxt_st.wdt_clr = nxt_st.aux[ACF_WDT_CLR_BIT];
        nxt_st.tm3_clr = nxt_st.aux[ACF_TM3_CLR_BIT];
        nxt_st.lvr_en = !nxt_st.aux[ACF_LVR_OFF_BIT];

        // Fields of the held configuration word
        nxt_st.cfg_valid = cfg_bus.valid;
        nxt_st.protect = !cfg_bus.cfg_word[ACF_PROT_N_BIT];
        nxt_st.xrst_en = !cfg_bus.cfg_word[ACF_XRST_N_BIT];
        nxt_st.lvr_thr = cfg_bus.cfg_word[ACF_LVR_THR_HI:ACF_LVR_THR_LO];
        nxt_st.tbl_block = I_TBL_ACC_REQ && I_TBL_ACC_LOCK_AREA
                           && !cfg_bus.cfg_word[ACF_TBL_LOCK_N_BIT];
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            st_ff <= ACF_STATE_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign O_HRDATA = st_ff.hrdata;
    assign O_HREADYOUT = st_ff.hreadyout;
    assign O_HRESP = ACF_HRESP_OKAY;
    assign O_CFG_VALID = st_ff.cfg_valid;
    assign O_WDT_CLEAR = st_ff.wdt_clr;
    assign O_TIMER3_CLEAR = st_ff.tm3_clr;
    assign O_TOUCH_START = st_ff.tk_start;
    assign O_ADC_START = st_ff.adc_start;
    assign O_TOUCH_BUSY = st_ff.aux[ACF_TOUCH_SOC_BIT];
    assign O_ADC_BUSY = st_ff.aux[ACF_ADC_SOC_BIT];
    assign O_TIMER1_COUNT_IN = st_ff.t1_in;
    assign O_TIMER2_COUNT_IN = st_ff.t2_in;
    assign O_LOW_VOLT_RESET_EN = st_ff.lvr_en;
    assign O_LOW_VOLT_THRESHOLD_SEL = st_ff.lvr_thr;
    assign O_CODE_PROTECT = st_ff.protect;
    assign O_EXT_PIN_RESET_EN = st_ff.xrst_en;
    assign O_TBL_ACC_BLOCK = st_ff.tbl_block;
endmodule
`default_nettype wire

// ### tb/acf_aux_ctrl_sva.sv
// Concurrent checks for the auxiliary control register and configuration word block.
// Assumes it is bound into the top module and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module acf_aux_ctrl_sva (
    // Clock, reset and bus
    input wire logic I_CLK_SYS,
    input wire logic I_RESET,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    // Block inputs
    input wire logic I_TOUCH_DONE,
    input wire logic I_SYSTEM_CLOCK_FAST,
    input wire logic I_ADC_DONE,
    input wire logic I_TIMER1_COUNTER_MODE,
    input wire logic I_TIMER2_COUNTER_MODE,
    input wire logic I_TBL_ACC_REQ,
    input wire logic I_TBL_ACC_LOCK_AREA,
    // Block outputs
    input wire logic O_CFG_VALID,
    input wire logic O_WDT_CLEAR,
    input wire logic O_TIMER3_CLEAR,
    input wire logic O_TOUCH_BUSY,
    input wire logic O_ADC_BUSY,
    input wire logic O_TIMER1_COUNT_IN,
    input wire logic O_TIMER2_COUNT_IN,
    input wire logic O_LOW_VOLT_RESET_EN,
    input wire logic [2:0] O_LOW_VOLT_THRESHOLD_SEL,
    input wire logic O_CODE_PROTECT,
    input wire logic O_EXT_PIN_RESET_EN,
    input wire logic O_TBL_ACC_BLOCK
);
    logic wr_ph_ff;
    logic nxt_wr_ph;

    // Word write address phase to the control register; high during its data phase
    assign nxt_wr_ph = I_HSEL & I_HREADY & I_HTRANS[1] & I_HWRITE & (I_HSIZE == 3'h2)
        & (I_HADDR == 32'h0000_03E0);
    always_ff @(posedge I_CLK_SYS) begin
        wr_ph_ff <= I_RESET ? 1'b0 : nxt_wr_ph;
    end

    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RESET);

    chk_wdt_pulse: assert property (
        wr_ph_ff && I_HWDATA[7] |=> O_WDT_CLEAR ##1 !O_WDT_CLEAR)
        else $error("watchdog clear pulse wrong");
    chk_tm3_pulse: assert property (
        wr_ph_ff && I_HWDATA[6] |=> O_TIMER3_CLEAR ##1 !O_TIMER3_CLEAR)
        else $error("timer3 clear pulse wrong");
    chk_touch_start: assert property (wr_ph_ff && I_HWDATA[5] |=> O_TOUCH_BUSY)
        else $error("touch start not set");
    chk_touch_done: assert property (
        O_TOUCH_BUSY && I_TOUCH_DONE && I_SYSTEM_CLOCK_FAST && !wr_ph_ff |=> !O_TOUCH_BUSY)
        else $error("touch bit not cleared at end");
    chk_touch_slow: assert property (
        O_TOUCH_BUSY && !I_SYSTEM_CLOCK_FAST && !wr_ph_ff |=> O_TOUCH_BUSY)
        else $error("touch bit cleared on slow clock");
    chk_adc_start: assert property (wr_ph_ff && I_HWDATA[4] |=> O_ADC_BUSY)
        else $error("adc start not set");
    chk_adc_done: assert property (
        O_ADC_BUSY && I_ADC_DONE && !wr_ph_ff |=> !O_ADC_BUSY)
        else $error("adc bit not cleared at end");
    chk_adc_sw_clear: assert property (wr_ph_ff && !I_HWDATA[4] |=> !O_ADC_BUSY)
        else $error("adc bit not cleared by write");
    chk_lvr_off: assert property (
        wr_ph_ff |=> ##1 O_LOW_VOLT_RESET_EN == !$past(I_HWDATA[3], 2))
        else $error("low voltage reset enable wrong");
    chk_t2_idle: assert property (
        !I_TIMER2_COUNTER_MODE [*3] |-> !O_TIMER2_COUNT_IN)
        else $error("timer2 count input outside counter mode");
    chk_t1_idle: assert property (
        !I_TIMER1_COUNTER_MODE [*3] |-> !O_TIMER1_COUNT_IN)
        else $error("timer1 count input outside counter mode");
    chk_tbl_cause: assert property (
        O_TBL_ACC_BLOCK |-> $past(I_TBL_ACC_REQ && I_TBL_ACC_LOCK_AREA))
        else $error("table block without request");
    chk_cfg_hold: assert property (
        O_CFG_VALID |=> $stable({O_CODE_PROTECT, O_EXT_PIN_RESET_EN, O_LOW_VOLT_THRESHOLD_SEL}))
        else $error("configuration outputs changed");

    cover property (wr_ph_ff && I_HWDATA[7] ##1 O_WDT_CLEAR);
    cover property (O_ADC_BUSY && I_ADC_DONE ##1 !O_ADC_BUSY);
    cover property (O_TOUCH_BUSY && I_TOUCH_DONE && I_SYSTEM_CLOCK_FAST ##1 !O_TOUCH_BUSY);
endmodule

bind acf_aux_ctrl_top acf_aux_ctrl_sva chk_i (.*);
`default_nettype wire

// ### tb/acf_aux_ctrl_tb.sv
// Self-checking bench for the auxiliary control register and configuration word block.
// Assumes a zero-wait AHB-Lite slave; the bench is the only bus master.
`timescale 1ns/1ps
`default_nettype none
module acf_aux_ctrl_tb;
    import acf_pkg::*;
    localparam logic [31:0] AUX = 32'(ACF_AUX_CTRL_IDX) << 2;
    localparam logic [31:0] CFG = 32'(ACF_CFG_WORD_IDX) << 2;
    logic I_CLK_SYS, I_RESET, I_HSEL, I_HWRITE, I_TOUCH_DONE, I_SYSTEM_CLOCK_FAST, I_ADC_DONE;
    logic I_SLOW_CLOCK, I_TIMER1_PIN, I_TIMER2_PIN, I_TIMER1_COUNTER_MODE, I_TIMER2_COUNTER_MODE;
    logic I_TBL_ACC_REQ, I_TBL_ACC_LOCK_AREA, O_HREADYOUT, O_HRESP, O_CFG_VALID, O_WDT_CLEAR;
    logic O_TIMER3_CLEAR, O_TOUCH_START, O_ADC_START, O_TOUCH_BUSY, O_ADC_BUSY, O_TIMER1_COUNT_IN;
    logic O_TIMER2_COUNT_IN, O_LOW_VOLT_RESET_EN, O_CODE_PROTECT, O_EXT_PIN_RESET_EN;
    logic O_TBL_ACC_BLOCK, rst_q, slow_q, tsel, tchk, t1_exp, t2_exp;
    logic [3:0] prev_in, dcnt, dcnt_q;
    logic [4:0] cfg_o;
    logic [31:0] I_HADDR, I_HWDATA, O_HRDATA, rnd;
    logic [1:0] I_HTRANS;
    logic [2:0] I_HSIZE, O_LOW_VOLT_THRESHOLD_SEL;
    logic [7:0] I_CFG_WORD, c;
    logic rd_pend;
    logic [31:0] expq[$];
    wire I_HREADY;
    int errors, cmp_count, seed, tick;
    int n_wdt, n_tm3, n_tk, n_adc;

    assign I_HREADY = O_HREADYOUT;
    assign cfg_o = {O_CODE_PROTECT, O_EXT_PIN_RESET_EN, O_LOW_VOLT_THRESHOLD_SEL};
    // Expected count inputs: pin, or slow clock over 16, one register behind the inputs
    assign t1_exp = prev_in[1] & (tsel ? dcnt_q[3] : prev_in[3]);
    assign t2_exp = prev_in[0] & (tsel ? dcnt_q[3] : prev_in[2]);
    acf_aux_ctrl_top uut (.*);

    initial begin
        I_CLK_SYS = 1'b0;
        forever #5 I_CLK_SYS = ~I_CLK_SYS;
    end

    // Free-running slow clock and random timer pins and modes
    always @(posedge I_CLK_SYS) begin
        tick <= tick + 1;
        rnd <= $random(seed);
        I_SLOW_CLOCK <= tick[2];
        {I_TIMER1_PIN, I_TIMER2_PIN, I_TIMER1_COUNTER_MODE, I_TIMER2_COUNTER_MODE} <= rnd[3:0];
    end

    // Read data is compared at the data-phase edge against the oldest note
    always @(posedge I_CLK_SYS) begin
        if (rd_pend && O_HREADYOUT === 1'b1) begin
            cmp(O_HRDATA, expq.pop_front());
            cmp(32'(O_HRESP), 32'(ACF_HRESP_OKAY));
        end
    end

    // Slow clock divider reference, pulse counts and per-cycle timer input checks
    always @(posedge I_CLK_SYS) begin
        rst_q <= I_RESET;
        prev_in <= {I_TIMER1_PIN, I_TIMER2_PIN, I_TIMER1_COUNTER_MODE, I_TIMER2_COUNTER_MODE};
        slow_q <= I_RESET ? 1'b0 : I_SLOW_CLOCK;
        dcnt <= I_RESET ? 4'h0 : dcnt + 4'(I_SLOW_CLOCK && !slow_q);
        dcnt_q <= dcnt;
        n_wdt <= n_wdt + int'(O_WDT_CLEAR === 1'b1);
        n_tm3 <= n_tm3 + int'(O_TIMER3_CLEAR === 1'b1);
        n_tk <= n_tk + int'(O_TOUCH_START === 1'b1);
        n_adc <= n_adc + int'(O_ADC_START === 1'b1);
        if (tchk && !rst_q) begin
            cmp(32'(O_TIMER1_COUNT_IN), 32'(t1_exp));
            cmp(32'(O_TIMER2_COUNT_IN), 32'(t2_exp));
        end
    end

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic rdy();
        do begin
            @(posedge I_CLK_SYS);
        end while (O_HREADYOUT !== 1'b1);
    endtask

    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge I_CLK_SYS);
        I_HSEL <= 1'b1;
        I_HTRANS <= 2'h2;
        I_HADDR <= a;
        I_HWRITE <= w;
        rdy();
        I_HSEL <= 1'b0;
        I_HTRANS <= 2'h0;
        I_HWDATA <= d;
        rd_pend <= !w;
        if (!w) expq.push_back(d);
        rdy();
        rd_pend <= 1'b0;
    endtask

    task automatic done_pulse(input logic fast, input logic adc);
        @(posedge I_CLK_SYS);
        I_SYSTEM_CLOCK_FAST <= fast;
        I_TOUCH_DONE <= !adc;
        I_ADC_DONE <= adc;
        @(posedge I_CLK_SYS);
        I_TOUCH_DONE <= 1'b0;
        I_ADC_DONE <= 1'b0;
    endtask

    task automatic test_done();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge I_CLK_SYS);
        errors++;
        test_done();
    end

    initial begin
        I_RESET = 1'b1;
        seed = 32'h7852;
        {tick, rnd, errors, cmp_count} = 128'h0;
        {n_wdt, n_tm3, n_tk, n_adc} = 128'h0;
        {rst_q, tsel, tchk} = 3'h5;
        {I_HSEL, I_HWRITE, I_TOUCH_DONE, I_SYSTEM_CLOCK_FAST, I_ADC_DONE, rd_pend} = 6'h00;
        {I_SLOW_CLOCK, I_TIMER1_PIN, I_TIMER2_PIN} = 3'h0;
        {I_TIMER1_COUNTER_MODE, I_TIMER2_COUNTER_MODE, I_TBL_ACC_REQ, I_TBL_ACC_LOCK_AREA} = 4'h0;
        {I_HADDR, I_HWDATA, I_HTRANS, I_HSIZE, I_CFG_WORD} = {64'h0, 2'h0, ACF_HSIZE_WORD, 8'h00};
        for (int k = 0; k < 8; k++) begin
            c = {rnd[7:6], 3'(k), rnd[2:0]};
            @(posedge I_CLK_SYS);
            I_RESET <= 1'b1;
            I_CFG_WORD <= c;
            repeat (11) @(posedge I_CLK_SYS);
            I_RESET <= 1'b0;
            for (int n = 0; n < 20 && O_CFG_VALID !== 1'b1; n++) @(posedge I_CLK_SYS);
            cmp(32'(cfg_o), 32'({~c[7:6], c[5:3]}));
            I_CFG_WORD <= ~c;
            I_TBL_ACC_REQ <= 1'b1;
            I_TBL_ACC_LOCK_AREA <= 1'b1;
            repeat (3) @(posedge I_CLK_SYS);
            cmp(32'(O_TBL_ACC_BLOCK), 32'(!c[1]));
            cmp(32'(cfg_o), 32'({~c[7:6], c[5:3]}));
            I_TBL_ACC_LOCK_AREA <= 1'b0;
            bus(CFG, 1'b1, 32'h0000_00FF);
            bus(CFG, 1'b0, 32'(c));
            cmp(32'(O_TBL_ACC_BLOCK), 32'h0);
        end
        bus(AUX, 1'b1, 32'h80);
        bus(AUX, 1'b1, 32'h40);
        bus(AUX, 1'b0, 32'h00);
        bus(AUX, 1'b1, 32'h10);
        bus(AUX, 1'b0, 32'h10);
        done_pulse(1'b0, 1'b1);
        bus(AUX, 1'b0, 32'h00);
        bus(AUX, 1'b1, 32'h10);
        bus(AUX, 1'b1, 32'h00);
        bus(AUX, 1'b0, 32'h00);
        bus(AUX, 1'b1, 32'h20);
        done_pulse(1'b0, 1'b0);
        bus(AUX, 1'b0, 32'h20);
        done_pulse(1'b1, 1'b0);
        bus(AUX, 1'b0, 32'h00);
        // Timer input checks pause while the select bits change
        tchk <= 1'b0;
        bus(AUX, 1'b1, 32'h0F);
        tsel <= 1'b1;
        repeat (3) @(posedge I_CLK_SYS);
        tchk <= 1'b1;
        cmp(32'(O_LOW_VOLT_RESET_EN), 32'h0);
        bus(AUX, 1'b0, 32'h0E);
        repeat (300) @(posedge I_CLK_SYS);
        tchk <= 1'b0;
        bus(AUX, 1'b1, 32'h00);
        tsel <= 1'b0;
        repeat (3) @(posedge I_CLK_SYS);
        tchk <= 1'b1;
        cmp(32'(O_LOW_VOLT_RESET_EN), 32'h1);
        bus(AUX + 32'h4, 1'b1, 32'hFF);
        bus(AUX + 32'h4, 1'b0, 32'h00);
        bus(AUX, 1'b0, 32'h00);
        repeat (2) @(posedge I_CLK_SYS);
        cmp(32'(n_wdt), 32'h1);
        cmp(32'(n_tm3), 32'h1);
        cmp(32'(n_tk), 32'h1);
        cmp(32'(n_adc), 32'h2);
        test_done();
    end
endmodule
`default_nettype wire
